// *** hdl/adcctl_defines.svh ***
// constants for the converter control block
`ifndef ADCCTL_DEFINES_SVH
`define ADCCTL_DEFINES_SVH
// register byte addresses
`define ADCCTL_OFS_CTRL0     12'h000
`define ADCCTL_OFS_CTRL1     12'h004
`define ADCCTL_OFS_RES_HI    12'h008
`define ADCCTL_OFS_RES_LO    12'h00C
`define ADCCTL_OFS_IRQ_STAT  12'h010
`define ADCCTL_OFS_IRQ_MASK  12'h014
`define ADCCTL_OFS_PIN_CFG   12'h018
// field positions
`define ADCCTL_BIT_START     7
`define ADCCTL_BIT_BUSY      6
`define ADCCTL_BIT_ENABLE    5
`define ADCCTL_BIT_JUSTIFY   4
`define ADCCTL_BIT_DONE      0
// reset values
`define ADCCTL_RST_CTRL0     8'h00
`define ADCCTL_RST_CTRL1     8'h00
`define ADCCTL_RST_PIN_CFG   8'h00
// valid pin mask: inputs 0 to 3 and 7
`define ADCCTL_PIN_MASK      8'h8F
// conversion clocks spent sampling before the bit decisions
`define ADCCTL_SAMPLE_TICKS  4
`endif

// *** hdl/adcctl_pkg.sv ***
// types shared by the converter control block
package adcctl_pkg;
  typedef struct packed {
    logic       start;
    logic       busy;
    logic       enable;
    logic       justify;
    logic [3:0] ext_ch;
  } adcctl_ctrl0_t;
  typedef struct packed {
    logic [2:0] source;
    logic [1:0] vref;
    logic [2:0] clkdiv;
  } adcctl_ctrl1_t;
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } adcctl_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } adcctl_apb_rsp_t;
  typedef enum logic [1:0] { ST_IDLE, ST_SAMPLE, ST_CONVERT } adcctl_state_t;
endpackage : adcctl_pkg

// *** hdl/adcctl_top.sv ***
// converter control registers, sequencer and input routing
// How it works
// - every conversion yields a twelve bit result, any source
// - justify 0: high byte bits 11..4, low byte bits 3..0 then zeros
// - justify 1: high byte zeros then bits 11..8, low byte bits 7..0
// - result byte positions carrying no result bit read as zero
// - while disabled both result registers keep their contents
// - conversion starts only after start bit written high then low
// - busy flag bit 6 sets once the start pulse completes
// - busy clears when conversion ends; zero means idle
// - enable bit 5 must be one; zero powers the converter down
// - channel codes 0..3 route inputs 0..3, 7 routes input 7
// - channel codes 8..15 select nothing, converter input floats
// - source field picks an internal signal or the external channel
// - one converter; only one input is routed at any time
// - analog pins lose digital function and pull-high resistor
// - source 000 external, 001..100 internal, 101..111 external again
// - clock field divides system clock by 1 up to 128
// - conversion end sets interrupt flag, raises interrupt if enabled
`include "adcctl_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module adcctl_top #(
  parameter int RES_W = 12
) (
  input  wire logic                     CLK_SYS,
  input  wire logic                     RESET,
  input  wire adcctl_pkg::adcctl_apb_req_t APB_REQ,
  output var  adcctl_pkg::adcctl_apb_rsp_t APB_RSP,
  input  wire logic                     SAR_CMP_HIGH,
  output logic [RES_W-1:0]              SAR_DAC_CODE,
  output logic                          ADC_POWER_EN,
  output logic                          ADC_SAMPLE,
  output logic                          ADC_VREF_INTERNAL,
  output logic [7:0]                    EXT_CH_SEL,
  output logic [3:0]                    INT_SRC_SEL,
  output logic [7:0]                    PIN_DIGITAL_OFF,
  output logic [7:0]                    PIN_PULLUP_OFF,
  output logic                          IRQ
);
  import adcctl_pkg::*;

  localparam int unsigned SAMPLE_LAST = `ADCCTL_SAMPLE_TICKS - 1;

  adcctl_ctrl0_t      ctrl0_r;
  adcctl_ctrl1_t      ctrl1_r;
  logic [7:0]         pin_cfg_r;
  logic [7:0]         irq_mask_r;
  logic               done_stat_r;
  logic [RES_W-1:0]   result_r;
  logic [RES_W-1:0]   code_r;
  logic [RES_W-1:0]   code_nxt;
  logic [RES_W-1:0]   bit_mask_r;
  logic [2:0]         samp_cnt_r;
  logic [6:0]         div_cnt_r;
  logic [6:0]         div_top;
  logic               tick;
  adcctl_state_t      state_r;
  logic               wr_setup;
  logic               rd_setup;
  logic               acc_done;
  logic               addr_ok;
  logic               wr_ctrl0;
  logic               launch;
  logic               conv_done;
  logic [7:0]         res_hi;
  logic [7:0]         res_lo;
  logic [7:0]         rd_val;
  logic [31:0]        prdata_r;
  logic               rd_stat_r;
  logic [11:0]        conv_cyc_r;
  logic [11:0]        conv_len;

  // apb phases; read data is captured in setup, writes land at access end
  assign acc_done = APB_REQ.psel & APB_REQ.penable;
  assign rd_setup = APB_REQ.psel & ~APB_REQ.penable & ~APB_REQ.pwrite;
  assign wr_setup = acc_done & APB_REQ.pwrite;

  // address decode
  always_comb begin
    case (APB_REQ.paddr)
      `ADCCTL_OFS_CTRL0, `ADCCTL_OFS_CTRL1, `ADCCTL_OFS_RES_HI,
      `ADCCTL_OFS_RES_LO, `ADCCTL_OFS_IRQ_STAT, `ADCCTL_OFS_IRQ_MASK,
      `ADCCTL_OFS_PIN_CFG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign wr_ctrl0 = wr_setup & (APB_REQ.paddr == `ADCCTL_OFS_CTRL0);

  assign launch = wr_ctrl0 & ctrl0_r.start
                & ~APB_REQ.pwdata[`ADCCTL_BIT_START]
                & ctrl0_r.enable & APB_REQ.pwdata[`ADCCTL_BIT_ENABLE]
                & (state_r == ST_IDLE);

  // control register 0, busy is hardware owned
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ctrl0_r <= `ADCCTL_RST_CTRL0;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_r.start   <= APB_REQ.pwdata[`ADCCTL_BIT_START];
        ctrl0_r.enable  <= APB_REQ.pwdata[`ADCCTL_BIT_ENABLE];
        ctrl0_r.justify <= APB_REQ.pwdata[`ADCCTL_BIT_JUSTIFY];
        ctrl0_r.ext_ch  <= APB_REQ.pwdata[3:0];
      end
      if (launch) begin
        ctrl0_r.busy <= 1'b1;
      end else if (conv_done | ~ctrl0_r.enable) begin
        ctrl0_r.busy <= 1'b0;
      end
    end
  end

  // control 1, pin configuration and interrupt mask
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ctrl1_r    <= `ADCCTL_RST_CTRL1;
      pin_cfg_r  <= `ADCCTL_RST_PIN_CFG;
      irq_mask_r <= 8'h00;
    end else if (wr_setup) begin
      case (APB_REQ.paddr)
        `ADCCTL_OFS_CTRL1:    ctrl1_r    <= APB_REQ.pwdata[7:0];
        `ADCCTL_OFS_PIN_CFG:  pin_cfg_r  <= APB_REQ.pwdata[7:0]
                                          & `ADCCTL_PIN_MASK;
        `ADCCTL_OFS_IRQ_MASK: irq_mask_r <= {7'h00, APB_REQ.pwdata[0]};
        default: ;
      endcase
    end
  end

  // divide by two to the power of the clock field
  assign div_top = 7'((8'h01 << ctrl1_r.clkdiv) - 8'h01);
  assign tick    = (div_cnt_r == div_top);

  // conversion clock divider, held while idle to align the first period
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      div_cnt_r <= 7'h00;
    end else if (state_r == ST_IDLE || tick) begin
      div_cnt_r <= 7'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 7'h01;
    end
  end

  // successive approximation step on the comparator decision
  always_comb begin
    code_nxt = SAR_CMP_HIGH ? code_r : (code_r & ~bit_mask_r);
    code_nxt = code_nxt | (bit_mask_r >> 1);
  end

  assign conv_done = (state_r == ST_CONVERT) & tick & bit_mask_r[0]
                   & ctrl0_r.enable;

  // sequencer: sample, then one decision per result bit
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_r    <= ST_IDLE;
      samp_cnt_r <= 3'h0;
      code_r     <= '0;
      bit_mask_r <= '0;
    end else if (~ctrl0_r.enable) begin
      state_r    <= ST_IDLE;
      bit_mask_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (launch) begin
            state_r    <= ST_SAMPLE;
            samp_cnt_r <= 3'h0;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            samp_cnt_r <= samp_cnt_r + 3'h1;
            if (samp_cnt_r == 3'(SAMPLE_LAST)) begin
              state_r    <= ST_CONVERT;
              code_r     <= {1'b1, {(RES_W-1){1'b0}}};
              bit_mask_r <= {1'b1, {(RES_W-1){1'b0}}};
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin
            code_r     <= code_nxt;
            bit_mask_r <= bit_mask_r >> 1;
            if (bit_mask_r[0]) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // result loads on the edge busy clears
  // only a finished enabled conversion loads it
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      result_r <= '0;
    end else if (conv_done) begin
      result_r <= code_nxt;
    end
  end

  // done flag sticky, set wins over the read clear
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      done_stat_r <= 1'b0;
    end else if (conv_done) begin
      done_stat_r <= 1'b1;
    end else if (rd_stat_r & acc_done) begin
      done_stat_r <= 1'b0;
    end
  end

  assign IRQ = done_stat_r & irq_mask_r[`ADCCTL_BIT_DONE];

  always_comb begin
    if (ctrl0_r.justify) begin
      res_hi = {4'h0, result_r[11:8]};
      res_lo = result_r[7:0];
    end else begin
      res_hi = result_r[11:4];
      res_lo = {result_r[3:0], 4'h0};
    end
  end

  // read multiplexer
  always_comb begin
    case (APB_REQ.paddr)
      `ADCCTL_OFS_CTRL0:    rd_val = ctrl0_r;
      `ADCCTL_OFS_CTRL1:    rd_val = ctrl1_r;
      `ADCCTL_OFS_RES_HI:   rd_val = res_hi;
      `ADCCTL_OFS_RES_LO:   rd_val = res_lo;
      `ADCCTL_OFS_IRQ_STAT: rd_val = {7'h00, done_stat_r};
      `ADCCTL_OFS_IRQ_MASK: rd_val = irq_mask_r;
      `ADCCTL_OFS_PIN_CFG:  rd_val = pin_cfg_r;
      default:              rd_val = 8'h00;
    endcase
  end

  // read data captured in setup phase
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      prdata_r  <= 32'h0000_0000;
      rd_stat_r <= 1'b0;
    end else if (rd_setup) begin
      prdata_r  <= {24'h00_0000, rd_val};
      rd_stat_r <= (APB_REQ.paddr == `ADCCTL_OFS_IRQ_STAT);
    end else if (acc_done) begin
      rd_stat_r <= 1'b0;
    end
  end

  // apb answer, no wait states
  always_comb begin
    APB_RSP.prdata  = prdata_r;
    APB_RSP.pready  = 1'b1;
    APB_RSP.pslverr = acc_done & ~addr_ok;
  end

  assign ADC_POWER_EN      = ctrl0_r.enable;
  assign ADC_SAMPLE        = (state_r == ST_SAMPLE);
  assign ADC_VREF_INTERNAL = (ctrl1_r.vref == 2'b01);
  assign SAR_DAC_CODE      = code_r;

  always_comb begin
    EXT_CH_SEL  = 8'h00;
    INT_SRC_SEL = 4'h0;
    if (ctrl0_r.enable) begin
      case (ctrl1_r.source)
        3'b001, 3'b010, 3'b011, 3'b100: begin
          INT_SRC_SEL = 4'(4'h1 << (ctrl1_r.source - 3'b001));
        end
        default: begin
          if (ctrl0_r.ext_ch[3] == 1'b0) begin
            EXT_CH_SEL = 8'(8'h01 << ctrl0_r.ext_ch[2:0])
                       & `ADCCTL_PIN_MASK;
          end
        end
      endcase
    end
  end

  // analog pins drop digital path and pull-high
  assign PIN_DIGITAL_OFF = pin_cfg_r;
  assign PIN_PULLUP_OFF  = pin_cfg_r;

  // expected busy span, sample plus bit ticks
  assign conv_len = 12'(`ADCCTL_SAMPLE_TICKS + RES_W) << ctrl1_r.clkdiv;

  // system cycles spent busy since the launch
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      conv_cyc_r <= 12'h000;
    end else if (launch) begin
      conv_cyc_r <= 12'h000;
    end else if (ctrl0_r.busy) begin
      conv_cyc_r <= conv_cyc_r + 12'h001;
    end
  end

  // checks next to the logic they guard
  a_busy_on_start: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    launch |=> ctrl0_r.busy ##1 ADC_SAMPLE)
    else $error("busy or sampling missing after start");
  a_start_pulse: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    $rose(ctrl0_r.busy) |-> $past(launch))
    else $error("busy rose without a start pulse");
  a_busy_clear: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    conv_done |=> !ctrl0_r.busy)
    else $error("busy still set after conversion end");
  a_off_no_busy: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    !ctrl0_r.enable |=> !ctrl0_r.busy && state_r == ST_IDLE)
    else $error("busy while disabled");
  a_result_hold: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    !ctrl0_r.enable |=> $stable(result_r))
    else $error("result changed while disabled");
  a_busy_result: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    $fell(ctrl0_r.busy) && $past(ctrl0_r.enable)
      |-> result_r == $past(code_nxt))
    else $error("result not loaded as busy fell");
  a_left_zero: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    !ctrl0_r.justify |-> res_lo[3:0] == 4'h0 && res_hi == result_r[11:4])
    else $error("left justified layout wrong");
  a_right_zero: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    ctrl0_r.justify |-> res_hi[7:4] == 4'h0 && res_lo == result_r[7:0])
    else $error("right justified layout wrong");
  a_route_channel: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    ctrl0_r.enable && !(ctrl1_r.source inside {[3'd1:3'd4]})
      && (ctrl0_r.ext_ch inside {[4'd0:4'd3], 4'd7})
      |-> EXT_CH_SEL[ctrl0_r.ext_ch[2:0]] && $onehot(EXT_CH_SEL))
    else $error("existing channel not routed");
  a_float_high: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    ctrl0_r.ext_ch[3] || ctrl0_r.ext_ch inside {[4:6]}
      |-> EXT_CH_SEL == 8'h00)
    else $error("missing channel routed");
  a_one_input: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    $onehot0({EXT_CH_SEL, INT_SRC_SEL}))
    else $error("two inputs routed");
  a_pin_analog: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    PIN_PULLUP_OFF == PIN_DIGITAL_OFF
      && (PIN_DIGITAL_OFF & ~`ADCCTL_PIN_MASK) == 8'h00)
    else $error("pin digital and pull-high controls differ");
  a_done_flag: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    conv_done |=> done_stat_r && (IRQ == irq_mask_r[0]))
    else $error("done flag or interrupt missing");
  a_div_full: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    ctrl1_r.clkdiv == 3'h0 && ADC_SAMPLE |-> tick)
    else $error("undivided clock missed tick");
  a_conv_length: assert property (
    @(posedge CLK_SYS) disable iff (RESET)
    conv_done |-> conv_cyc_r == conv_len - 12'h001)
    else $error("conversion length does not match divider");
endmodule : adcctl_top
`default_nettype wire

// *** sim/adcctl_top_tb.sv ***
// self-checking bench for the converter control block
`include "adcctl_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module adcctl_top_tb;
  import adcctl_pkg::*;
  logic            clk_sys;
  logic            reset;
  adcctl_apb_req_t req;
  adcctl_apb_rsp_t rsp;
  logic            cmp_high;
  logic [11:0]     dac_code;
  logic [11:0]     ain;
  logic [7:0]      ext_sel;
  logic [3:0]      int_sel;
  logic [7:0]      dig_off;
  logic [7:0]      pu_off;
  logic            pwr_en;
  logic            irq;
  logic [7:0]      rd;
  logic            err;
  int              n_errors = 0;
  int              tests_run = 0;
  int              cyc = 0;

  adcctl_top u_adcctl_top (
    .CLK_SYS(clk_sys), .RESET(reset), .APB_REQ(req), .APB_RSP(rsp),
    .SAR_CMP_HIGH(cmp_high), .SAR_DAC_CODE(dac_code),
    .ADC_POWER_EN(pwr_en), .ADC_SAMPLE(), .ADC_VREF_INTERNAL(),
    .EXT_CH_SEL(ext_sel), .INT_SRC_SEL(int_sel),
    .PIN_DIGITAL_OFF(dig_off), .PIN_PULLUP_OFF(pu_off), .IRQ(irq)
  );

  // system clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // comparator stand-in: analog level against the trial code
  always @(posedge clk_sys) begin
    cmp_high <= (ain >= dac_code);
  end

  // watchdog against a hung run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic is_wr, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    req <= '{a, 1'b1, 1'b0, is_wr, {24'h0, d}};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 40);
    if (n >= 40) n_errors++;
    rd = rsp.prdata[7:0];
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rdc

  // start pulse, then poll busy and time the conversion
  task automatic conv(input logic [11:0] v, input logic [7:0] c0,
                      input logic [2:0] div);
    realtime t0;
    int      n;
    int      el;
    ain = v;
    wr(`ADCCTL_OFS_CTRL1, {5'h00, div});
    wr(`ADCCTL_OFS_CTRL0, c0 | 8'h80);
    wr(`ADCCTL_OFS_CTRL0, c0);
    t0 = $realtime;
    rdc(`ADCCTL_OFS_CTRL0, c0 | 8'h40);
    n = 0;
    do begin
      apb(1'b0, `ADCCTL_OFS_CTRL0, 8'h00);
      n++;
    end while (rd[6] !== 1'b0 && n < 200);
    el = int'(($realtime - t0) / 4.0);
    chk(el >= (16 << div) && el <= (16 << div) + 12, 1);
  endtask : conv

  task automatic t_reset;
    rdc(`ADCCTL_OFS_CTRL0, 8'h00);
    rdc(`ADCCTL_OFS_CTRL1, 8'h00);
    chk(irq, 1'b0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_just0;
    wr(`ADCCTL_OFS_IRQ_MASK, 8'h01);
    conv(12'hA5C, 8'h20, 3'd2);
    rdc(`ADCCTL_OFS_RES_HI, 8'hA5);
    rdc(`ADCCTL_OFS_RES_LO, 8'hC0);
    chk(irq, 1'b1);
    rdc(`ADCCTL_OFS_IRQ_STAT, 8'h01);
    #1 chk(irq, 1'b0);
    rdc(`ADCCTL_OFS_IRQ_STAT, 8'h00);
    $display("left justify test done");
  endtask : t_just0

  task automatic t_just1;
    wr(`ADCCTL_OFS_CTRL0, 8'h30);
    rdc(`ADCCTL_OFS_RES_HI, 8'h0A);
    rdc(`ADCCTL_OFS_RES_LO, 8'h5C);
    wr(`ADCCTL_OFS_IRQ_MASK, 8'h00);
    conv(12'h3E7, 8'h30, 3'd3);
    rdc(`ADCCTL_OFS_RES_HI, 8'h03);
    rdc(`ADCCTL_OFS_RES_LO, 8'hE7);
    chk(irq, 1'b0);
    rdc(`ADCCTL_OFS_IRQ_STAT, 8'h01);
    $display("right justify test done");
  endtask : t_just1

  task automatic t_disabled;
    ain = 12'h123;
    wr(`ADCCTL_OFS_CTRL0, 8'hB0);
    wr(`ADCCTL_OFS_CTRL0, 8'h30);
    wr(`ADCCTL_OFS_CTRL0, 8'h10);
    rdc(`ADCCTL_OFS_IRQ_STAT, 8'h00);
    wr(`ADCCTL_OFS_CTRL0, 8'h90);
    wr(`ADCCTL_OFS_CTRL0, 8'h10);
    rdc(`ADCCTL_OFS_CTRL0, 8'h10);
    rdc(`ADCCTL_OFS_RES_HI, 8'h03);
    rdc(`ADCCTL_OFS_RES_LO, 8'hE7);
    chk(pwr_en, 1'b0);
    $display("disabled test done");
  endtask : t_disabled

  // channel and source decoding onto the single converter
  task automatic t_route;
    logic [3:0] chs [7] = '{0, 1, 2, 3, 7, 8, 15};
    wr(`ADCCTL_OFS_CTRL1, 8'h00);
    foreach (chs[i]) begin
      wr(`ADCCTL_OFS_CTRL0, {4'h2, chs[i]});
      #1 chk(ext_sel, chs[i] < 8 ? 8'h01 << chs[i] : 8'h00);
      chk(pwr_en, 1'b1);
    end
    wr(`ADCCTL_OFS_CTRL0, 8'h23);
    for (int s = 1; s < 8; s++) begin
      wr(`ADCCTL_OFS_CTRL1, 8'(s << 5));
      #1 chk(int_sel, s < 5 ? 4'h1 << (s - 1) : 4'h0);
      chk(ext_sel, s > 4 ? 8'h08 : 8'h00);
    end
    wr(`ADCCTL_OFS_CTRL0, 8'h03);
    #1 chk(ext_sel, 8'h00);
    $display("routing test done");
  endtask : t_route

  task automatic t_misc;
    wr(`ADCCTL_OFS_PIN_CFG, 8'hFF);
    rdc(`ADCCTL_OFS_PIN_CFG, 8'h8F);
    #1 chk(pu_off, 8'h8F);
    chk(dig_off, 8'h8F);
    apb(1'b0, 12'h020, 8'h00);
    chk(err, 1'b1);
    chk(rd, 8'h00);
    $display("pins and unmapped test done");
  endtask : t_misc

  task final_report;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // reset, then the scenarios in turn
  initial begin
    reset = 1'b1;
    req = '0;
    ain = 12'h000;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_just0();
    t_just1();
    t_disabled();
    t_route();
    t_misc();
    final_report();
  end
endmodule : adcctl_top_tb
`default_nettype wire
